// file: verilog/tmc_cfg.svh
// Constants for the trigger match comparator: offsets, fields, resets.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
`define TMC_HART_REGISTER_WIDTH 64
`define TMC_OFS_CTRL 5'h00
`define TMC_OFS_CMP_LO 5'h04
`define TMC_OFS_CMP_HI 5'h08
`define TMC_OFS_STATUS 5'h0c
`define TMC_OFS_CLEAR 5'h10
`define TMC_OFS_ENABLE 5'h14
`define TMC_BIT_LOAD 0
`define TMC_BIT_STORE 1
`define TMC_BIT_EXEC 2
`define TMC_BIT_U 3
`define TMC_BIT_S 4
`define TMC_BIT_M 6
`define TMC_MATCH_LSB 7
`define TMC_MATCH_MSB 10
`define TMC_BIT_SELECT 21
`define TMC_CTRL_RST 32'h0000_0000
`define TMC_CMP_RST 64'h0
`define TMC_PRIV_U 2'h0
`define TMC_PRIV_S 2'h1
`define TMC_PRIV_M 2'h3
`endif

// file: verilog/tmc_pkg.sv
// Types for the trigger match comparator.
// Assumes tmc_cfg.svh constants are used alongside.
package tmc_pkg;
  typedef enum logic [3:0] {
    TMC_EQ = 4'h0,
    TMC_NAPOT = 4'h1,
    TMC_GE = 4'h2,
    TMC_LT = 4'h3,
    TMC_MLOW = 4'h4,
    TMC_MHIGH = 4'h5,
    TMC_NEQ = 4'h8,
    TMC_NNAPOT = 4'h9,
    TMC_NMLOW = 4'hc,
    TMC_NMHIGH = 4'hd
  } tmc_match_type;
  typedef logic [63:0] tmc_word_type;
  typedef logic [1:0] tmc_priv_type;
  typedef logic [1:0] tmc_size_type;
endpackage

// file: verilog/tmc_comparator.sv
// One hardware trigger: compare, qualify, and a register slave.
// Assumes pipeline inputs on the same clock and a polling or irq driver.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"
module tmc_comparator #(
  parameter bit HAS_S = 1'b1,
  parameter bit HAS_U = 1'b1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire tmc_pkg::tmc_priv_type priv_mode,
  input wire logic mode_width32,
  input wire logic exec_valid,
  input wire tmc_pkg::tmc_word_type exec_addr,
  input wire tmc_pkg::tmc_word_type exec_opcode,
  input wire tmc_pkg::tmc_size_type exec_size,
  input wire logic load_valid,
  input wire tmc_pkg::tmc_word_type load_addr,
  input wire tmc_pkg::tmc_word_type load_data,
  input wire tmc_pkg::tmc_size_type load_size,
  input wire logic store_valid,
  input wire tmc_pkg::tmc_word_type store_addr,
  input wire tmc_pkg::tmc_word_type store_data,
  input wire tmc_pkg::tmc_size_type store_size,
  output logic trigger_hit,
  output logic [2:0] hit_source,
  output logic irq
);
  import tmc_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  tmc_word_type trigger_compare_value_reg;
  tmc_word_type trigger_compare_value_next;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] enable_reg;
  logic [2:0] enable_next;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic trigger_hit_reg;
  logic [2:0] hit_source_reg;

  // Bus decode; one wait state so read data come from a flop
  wire req = read | write;
  wire do_write = write & ack_reg;
  wire sel_ctrl = address == `TMC_OFS_CTRL;
  wire sel_lo = address == `TMC_OFS_CMP_LO;
  wire sel_hi = address == `TMC_OFS_CMP_HI;
  wire sel_status = address == `TMC_OFS_STATUS;
  wire sel_clear = address == `TMC_OFS_CLEAR;
  wire sel_enable = address == `TMC_OFS_ENABLE;
  wire [31:0] be_mask;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
      assign be_mask[gl*8 +: 8] = {8{byteenable[gl]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic legal_match(input logic [3:0] code);
    case (code)
      TMC_EQ, TMC_NAPOT, TMC_GE, TMC_LT, TMC_MLOW, TMC_MHIGH,
      TMC_NEQ, TMC_NNAPOT, TMC_NMLOW, TMC_NMHIGH: legal_match = 1'b1;
      default: legal_match = 1'b0;
    endcase
  endfunction

  wire [31:0] ctrl_wr = merge(ctrl_reg, writedata, be_mask);
  wire [3:0] match_wr = ctrl_wr[`TMC_MATCH_MSB:`TMC_MATCH_LSB];
  // Reserved codes keep the previous encoding
  wire [3:0] match_keep = legal_match(match_wr) ? match_wr :
                          ctrl_reg[`TMC_MATCH_MSB:`TMC_MATCH_LSB];
  wire [31:0] ctrl_legal = {10'h0, ctrl_wr[`TMC_BIT_SELECT], 10'h0,
                            match_keep, ctrl_wr[`TMC_BIT_M], 1'b0,
                            ctrl_wr[`TMC_BIT_S] & HAS_S,
                            ctrl_wr[`TMC_BIT_U] & HAS_U,
                            ctrl_wr[`TMC_BIT_EXEC],
                            ctrl_wr[`TMC_BIT_STORE],
                            ctrl_wr[`TMC_BIT_LOAD]};

  assign ctrl_next = (do_write & sel_ctrl) ? ctrl_legal : ctrl_reg;
  assign trigger_compare_value_next = {
    (do_write & sel_hi) ?
      merge(trigger_compare_value_reg[63:32], writedata, be_mask) :
      trigger_compare_value_reg[63:32],
    (do_write & sel_lo) ?
      merge(trigger_compare_value_reg[31:0], writedata, be_mask) :
      trigger_compare_value_reg[31:0]};
  wire [31:0] enable_wr = merge({29'h0, enable_reg}, writedata, be_mask);
  assign enable_next = (do_write & sel_enable) ? enable_wr[2:0] : enable_reg;

  // Control fields
  wire [3:0] match_code = ctrl_reg[`TMC_MATCH_MSB:`TMC_MATCH_LSB];
  wire data_sel = ctrl_reg[`TMC_BIT_SELECT];
  wire [2:0] src_en = {ctrl_reg[`TMC_BIT_LOAD], ctrl_reg[`TMC_BIT_STORE],
                       ctrl_reg[`TMC_BIT_EXEC]};
  // Privilege qualification; code 2 is not a valid mode, never matches
  wire priv_is_m = priv_mode == `TMC_PRIV_M;
  wire priv_is_s = priv_mode == `TMC_PRIV_S;
  wire priv_is_u = priv_mode == `TMC_PRIV_U;
  wire mode_m_ok = priv_is_m & ctrl_reg[`TMC_BIT_M];
  wire mode_s_ok = priv_is_s & ctrl_reg[`TMC_BIT_S];
  wire mode_u_ok = priv_is_u & ctrl_reg[`TMC_BIT_U];
  wire mode_ok = mode_m_ok | mode_s_ok | mode_u_ok;

  // Source arrays: index 0 execute, 1 store, 2 load
  wire [2:0] src_valid = {load_valid, store_valid, exec_valid};
  tmc_word_type src_value [3];
  tmc_size_type src_size [3];
  assign src_value[0] = data_sel ? exec_opcode : exec_addr;
  assign src_value[1] = data_sel ? store_data : store_addr;
  assign src_value[2] = data_sel ? load_data : load_addr;
  assign src_size[0] = exec_size;
  assign src_size[1] = store_size;
  assign src_size[2] = load_size;

  // Width of the current mode
  wire [63:0] mode_mask = mode_width32 ? 64'h0000_0000_ffff_ffff :
                          64'hffff_ffff_ffff_ffff;
  wire [2:0] src_match;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_src
      wire [63:0] size_mask;
      wire [63:0] wm;
      wire [63:0] vm;
      wire [63:0] tm;
      wire [63:0] care;
      wire [31:0] v_lo;
      wire [31:0] v_hi;
      wire [31:0] t_lo;
      wire [31:0] t_hi;
      wire eq;
      wire napot;
      wire ge;
      wire lt;
      wire mlow;
      wire mhigh;
      logic hit;
      assign size_mask = src_size[gi] == 2'h0 ? 64'h0000_0000_0000_00ff :
                         src_size[gi] == 2'h1 ? 64'h0000_0000_0000_ffff :
                         src_size[gi] == 2'h2 ? 64'h0000_0000_ffff_ffff :
                         64'hffff_ffff_ffff_ffff;
      assign wm = data_sel ? (mode_mask & size_mask) : mode_mask;
      assign vm = src_value[gi] & wm;
      assign tm = trigger_compare_value_reg & wm;
      assign eq = vm == tm;
      // Ones above the lowest zero of the compare register: the top M bits
      assign care = ~(tm ^ (tm + 64'h1)) & wm;
      assign napot = ((vm ^ tm) & care) == 64'h0;
      assign ge = vm >= tm;
      assign lt = vm < tm;
      assign v_lo = mode_width32 ? {16'h0, vm[15:0]} : vm[31:0];
      assign v_hi = mode_width32 ? {16'h0, vm[31:16]} : vm[63:32];
      assign t_lo = mode_width32 ? {16'h0, tm[15:0]} : tm[31:0];
      assign t_hi = mode_width32 ? {16'h0, tm[31:16]} : tm[63:32];
      assign mlow = (v_lo & t_hi) == t_lo;
      assign mhigh = (v_hi & t_hi) == t_lo;
      always_comb begin
        case (match_code)
          TMC_EQ: hit = eq;
          TMC_NAPOT: hit = napot;
          TMC_GE: hit = ge;
          TMC_LT: hit = lt;
          TMC_MLOW: hit = mlow;
          TMC_MHIGH: hit = mhigh;
          TMC_NEQ: hit = ~eq;
          TMC_NNAPOT: hit = ~napot;
          TMC_NMLOW: hit = ~mlow;
          TMC_NMHIGH: hit = ~mhigh;
          default: hit = 1'b0;
        endcase
      end
      wire qualified = src_valid[gi] & src_en[gi] & mode_ok;
      assign src_match[gi] = hit & qualified;
    end
  endgenerate

  // Sticky per-source status; a new hit wins over a clear in the same cycle
  wire clr_strobe = do_write & sel_clear;
  wire [2:0] clr_bits = clr_strobe ? (writedata[2:0] & be_mask[2:0]) : 3'h0;
  wire [2:0] status_kept = status_reg & ~clr_bits;
  assign status_next = status_kept | src_match;

  // Read lanes are ORed; unmapped offsets and the clear register read 0
  wire [31:0] rd_ctrl = sel_ctrl ? ctrl_reg : 32'h0;
  wire [31:0] rd_lo = sel_lo ? trigger_compare_value_reg[31:0] : 32'h0;
  wire [31:0] rd_hi = sel_hi ? trigger_compare_value_reg[63:32] : 32'h0;
  wire [31:0] rd_status = sel_status ? {29'h0, status_reg} : 32'h0;
  wire [31:0] rd_enable = sel_enable ? {29'h0, enable_reg} : 32'h0;
  assign readdata_next = rd_ctrl | rd_lo | rd_hi | rd_status | rd_enable;

  // Acknowledge toggles so every request sees exactly one wait state
  wire ack_next = req & ~ack_reg;
  wire trigger_hit_next = |src_match;
  wire [2:0] hit_source_next = src_match;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `TMC_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trigger_compare_value_reg <= `TMC_CMP_RST;
    end else begin
      trigger_compare_value_reg <= trigger_compare_value_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= 3'h0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Captured every cycle; only the acknowledged cycle is looked at
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      readdata_reg <= 32'h0;
    end else begin
      readdata_reg <= readdata_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trigger_hit_reg <= 1'b0;
    end else begin
      trigger_hit_reg <= trigger_hit_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hit_source_reg <= 3'h0;
    end else begin
      hit_source_reg <= hit_source_next;
    end
  end

  assign waitrequest = req & ~ack_reg;
  assign readdata = readdata_reg;
  assign trigger_hit = trigger_hit_reg;
  assign hit_source = hit_source_reg;
  // Level output straight from registered state
  assign irq = |(status_reg & enable_reg);
endmodule
`default_nettype wire

// file: sim/tmc_hart_model.sv
// Hart pipeline stand-in that drives the compare inputs.
// Assumes the bench calls issue for each access cycle.
`timescale 1ns/100ps
`default_nettype none
module tmc_hart_model (
  input wire logic clock,
  output tmc_pkg::tmc_word_type addr,
  output tmc_pkg::tmc_word_type data,
  output tmc_pkg::tmc_size_type size,
  output logic [2:0] valid
);
  import tmc_pkg::*;
  initial begin
    addr = 64'h5a5a_0f0f_a5a5_f0f0;
    data = 64'h0f0f_5a5a_f0f0_a5a5;
    size = 2'h0;
    valid = 3'h0;
  end
  // Stale addr and data lines turn to the inverse, never keep a lucky value; size keeps its value
  task automatic issue(input logic [2:0] s, input tmc_word_type a, d,
      input tmc_size_type sz);
    @(posedge clock);
    valid <= s;
    addr <= a;
    data <= d;
    size <= sz;
    @(posedge clock);
    valid <= 3'h0;
    addr <= ~a;
    data <= ~d;
  endtask
endmodule
`default_nettype wire

// file: sim/tmc_assertions.sv
// Port checker for the trigger match comparator.
// Assumes one clock domain and a master that drops requests between calls.
`timescale 1ns/100ps
`default_nettype none
module tmc_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire tmc_pkg::tmc_priv_type priv_mode,
  input wire logic exec_valid,
  input wire logic load_valid,
  input wire logic store_valid,
  input wire logic trigger_hit,
  input wire logic [2:0] hit_source
);
  import tmc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_req_start;
    (read || write) && !$past(read || write);
  endsequence
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_bus_handshake: assert property (s_req_start |-> s_one_wait)
    else $error("request not answered after one wait state");
  a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  a_hit_any: assert property (trigger_hit == (hit_source != 3'h0))
    else $error("hit flag and source disagree");
  a_exec_cause: assert property (hit_source[0] |-> $past(exec_valid))
    else $error("execute hit without execute access");
  a_store_cause: assert property (hit_source[1] |-> $past(store_valid))
    else $error("store hit without store access");
  a_load_cause: assert property (hit_source[2] |-> $past(load_valid))
    else $error("load hit without load access");
  a_mode_gate: assert property ($past(priv_mode) == 2'h2 |-> !trigger_hit)
    else $error("hit in a mode with no enable");
  a_quiet_pipe: assert property (!exec_valid && !load_valid && !store_valid
    |=> !trigger_hit) else $error("hit without any access");
endmodule
bind tmc_comparator tmc_checker i_tmc_checker (.clock(clock), .nrst(nrst),
  .read(read), .write(write), .waitrequest(waitrequest),
  .priv_mode(priv_mode), .exec_valid(exec_valid), .load_valid(load_valid),
  .store_valid(store_valid), .trigger_hit(trigger_hit),
  .hit_source(hit_source));
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the trigger match comparator.
// Assumes tmc_cfg.svh on the include path and the hart stand-in.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import tmc_pkg::*;
  logic clock, nrst, read, write, mode_width32, waitrequest, trigger_hit, irq;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [2:0] hit_source, valid;
  tmc_priv_type priv_mode;
  tmc_word_type addr, data;
  tmc_size_type size;
  logic [31:0] lfsr = 32'h90a031e0;
  int fails = 0;
  int checked = 0;
  tmc_comparator i_tmc_comparator (.clock(clock), .nrst(nrst),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .priv_mode(priv_mode), .mode_width32(mode_width32),
    .exec_valid(valid[0]), .exec_addr(addr), .exec_opcode(data),
    .exec_size(size), .load_valid(valid[2]), .load_addr(addr),
    .load_data(data), .load_size(size), .store_valid(valid[1]),
    .store_addr(addr), .store_data(data), .store_size(size),
    .trigger_hit(trigger_hit), .hit_source(hit_source), .irq(irq));
  tmc_hart_model i_tmc_hart_model (.clock(clock), .addr(addr), .data(data),
    .size(size), .valid(valid));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h80200003 : 32'h0);
    return lfsr;
  endfunction
  function automatic logic hit_of(logic [3:0] code, logic [63:0] c, v,
      logic w, s, logic [1:0] sz);
    int n, h, k;
    logic [63:0] hm;
    logic r;
    n = s ? 8 << sz : 64;
    if (w && n > 32) n = 32;
    c &= (n == 64) ? '1 : (64'h1 << n) - 1;
    v &= (n == 64) ? '1 : (64'h1 << n) - 1;
    h = w ? 16 : 32;
    hm = (64'h1 << h) - 1;
    k = 0;
    while (k < n && c[k]) k++;
    case (code[2:0])
      3'h0: r = c == v;
      3'h1: r = ((c ^ v) >> (k + 1)) == 64'h0;
      3'h2: r = v >= c;
      3'h3: r = v < c;
      3'h4: r = (v & hm & (c >> h)) == (c & hm);
      default: r = ((v >> h) & hm & (c >> h)) == (c & hm);
    endcase
    return r ^ code[3];
  endfunction
  // Wait state is polled, never assumed
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest && n < 50);
    // Taken at the edge where waitrequest is seen low
    rd = readdata;
    if (waitrequest) fails++;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #80000;
    fails++;
    wrap_up;
  end
  initial begin
    static logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
      4'h8, 4'h9, 4'hc, 4'hd};
    static logic [3:0] resv [6] = '{4'h6, 4'h7, 4'ha, 4'hb, 4'he, 4'hf};
    logic [63:0] cmp, v, d;
    logic [31:0] ctl;
    logic [3:0] code;
    logic [2:0] src, ex;
    logic [1:0] p, sz;
    logic w, s, mok;
    {nrst, read, write, mode_width32} = 4'h0;
    {address, writedata, priv_mode} = '0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 28; a += 4) begin
      bus(1'b0, 5'(a), 32'h0);
      `CHK("reset reg", 32'h0, rd)
    end
    $display("test reset done");
    foreach (resv[j]) begin
      bus(1'b1, `TMC_OFS_CTRL, 32'h1 << `TMC_MATCH_LSB);
      bus(1'b1, `TMC_OFS_CTRL, {28'h0, resv[j]} << `TMC_MATCH_LSB);
      bus(1'b0, `TMC_OFS_CTRL, 32'h0);
      `CHK("match field", 4'h1, rd[10:7])
    end
    $display("test reserved done");
    for (int i = 0; i < 300; i++) begin
      code = codes[rnd() % 10];
      s = code < 4'h4 && rnd() % 2;
      cmp = {rnd(), rnd()};
      if (code[2:0] == 3'h1) cmp[0] = 1'b0;
      v = cmp ^ (64'(rnd() % 4) << (rnd() % 64));
      d = v ^ (64'h1 << (rnd() % 64));
      ctl = (rnd() & 32'h5f) | {10'h0, s, 10'h0, code, 7'h0};
      {p, w, sz, src} = 8'(rnd());
      bus(1'b1, `TMC_OFS_CMP_LO, cmp[31:0]);
      bus(1'b1, `TMC_OFS_CMP_HI, cmp[63:32]);
      bus(1'b1, `TMC_OFS_CTRL, ctl);
      priv_mode <= p;
      mode_width32 <= w;
      mok = p == 2'h3 ? ctl[6] : p == 2'h1 ? ctl[4] : p == 2'h0 && ctl[3];
      ex = src & {ctl[0], ctl[1], ctl[2]} & {3{mok}};
      if (!hit_of(code, cmp, s ? d : v, w, s, sz)) ex = 3'h0;
      i_tmc_hart_model.issue(src, v, d, sz);
      #1 `CHK("hit_source", ex, hit_source)
      `CHK("trigger_hit", |ex, trigger_hit)
    end
    $display("test matching done");
    bus(1'b1, `TMC_OFS_CLEAR, 32'h7);
    bus(1'b1, `TMC_OFS_ENABLE, 32'h4);
    bus(1'b1, `TMC_OFS_CMP_LO, 32'h0);
    bus(1'b1, `TMC_OFS_CMP_HI, 32'h0);
    bus(1'b1, `TMC_OFS_CTRL, 32'h41);
    priv_mode <= 2'h3;
    i_tmc_hart_model.issue(3'h4, 64'h0, 64'h0, 2'h3);
    #1 `CHK("load hit", 3'h4, hit_source)
    @(posedge clock);
    #1 `CHK("irq", 1'b1, irq)
    bus(1'b1, `TMC_OFS_ENABLE, 32'h0);
    @(posedge clock);
    #1 `CHK("masked irq", 1'b0, irq)
    bus(1'b1, `TMC_OFS_CLEAR, 32'h4);
    bus(1'b0, `TMC_OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    $display("test interrupt done");
    wrap_up;
  end
endmodule
`default_nettype wire
